//--- src/chfg_pkg.sv
// Purpose: shared constants of the channel fault, gain and status block
// Assumes: 32-bit AHB-Lite register bus, 250 MHz mclk
// Notes:   gain is in units of 1/512
package chfg_pkg;
    localparam int          NCH         = 16;
    localparam int          CLK_MHZ     = 250;
    localparam int          ONTIME_NS   = 10000;
    localparam int          ONTIME_CYC  = (ONTIME_NS * CLK_MHZ + 999) / 1000;
    localparam int          ONT_W       = 12;
    localparam int          DAC_W       = 8;
    localparam int          GAIN_W      = 11;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  OFS_CFG0    = 8'h00;
    localparam logic [7:0]  OFS_CFG1    = 8'h04;
    localparam logic [7:0]  OFS_CHANNEL_SELECT_REG   = 8'h08;
    localparam logic [7:0]  OFS_CHANNEL_STATUS_REG   = 8'h0C;
    localparam logic [7:0]  OFS_LAT     = 8'h10;
    localparam logic [7:0]  OFS_IRQST   = 8'h14;
    localparam logic [7:0]  OFS_IRQMSK  = 8'h18;
    localparam logic [7:0]  OFS_GAIN    = 8'h1C;
    // ==========================================================
    // field positions
    localparam int          B_OPEN_AUTO_DISCONNECT      = 0;
    localparam int          B_CSR_EN    = 1;
    localparam int          B_DAC_OVERFLOW_FLAG      = 2;
    localparam int          B_FLTPIN    = 3;
    localparam int          B_RANGE     = 6;
    localparam int          B_FMT       = 8;
    localparam int          IRQ_FAULT   = 0;
    localparam int          IRQ_DAC_OVERFLOW_FLAG    = 1;
    localparam int          IRQ_QDONE   = 2;
    localparam int          NIRQ        = 3;
    // ==========================================================
    // data formats
    localparam logic [1:0]  FMT_16X16   = 2'h0;
    localparam logic [1:0]  FMT_256     = 2'h1;
    localparam logic [1:0]  FMT_192     = 2'h2;
    // ==========================================================
    // reset values and gain arithmetic
    localparam logic [15:0] RST_CFG1    = 16'h0040;
    localparam logic [15:0] RST_CHANNEL_SELECT_REG   = 16'hFFFF;
    localparam logic [15:0] RST_LAT     = 16'h0000;
    localparam logic [GAIN_W-1:0] GAIN_ONE = 11'd512;
    localparam logic [GAIN_W-1:0] R0_BASE  = 11'd384;
    localparam int          NQ          = 5;
    typedef enum logic [2:0] {Q_CFG0, Q_CFG1, Q_CHANNEL_SELECT_REG, Q_CHANNEL_STATUS_REG, Q_LAT} chfg_qsel_type;
endpackage

//--- src/chfg_ontime.sv
// Purpose: per-channel PWM on-time counters
// Assumes: drive is the channel's actual on state
// Notes:   met stays high while the channel has been on long enough
`timescale 1ns/100ps
module chfg_ontime #(
    parameter int NCH   = chfg_pkg::NCH,
    parameter int LIMIT = chfg_pkg::ONTIME_CYC
) (
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic [NCH-1:0] drive,
    output logic      [NCH-1:0] met
);
    import chfg_pkg::*;
    logic [ONT_W-1:0] cnt_q [NCH];
    logic [ONT_W-1:0] cnt_d [NCH];
    localparam logic [ONT_W-1:0] LIM = ONT_W'(LIMIT);

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (!drive[i])
                cnt_d[i] = '0;
            else if (cnt_q[i] != LIM)
                cnt_d[i] = cnt_q[i] + 1'b1;
            else
                cnt_d[i] = cnt_q[i];
            met[i] = (cnt_q[i] == LIM);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst)
                cnt_q[i] <= '0;
            else
                cnt_q[i] <= cnt_d[i];
        end
    end
endmodule // chfg_ontime

//--- src/chfg_gain.sv
// Purpose: current generator gain from code and range
// Assumes: code unsigned 0..63
// Notes:   result in units of 1/512, registered
`timescale 1ns/100ps
module chfg_gain (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [5:0]                  code,
    input  wire logic                        range,
    output logic      [chfg_pkg::GAIN_W-1:0] gain
);
    import chfg_pkg::*;
    logic [GAIN_W-1:0] gain_d;

    always_comb begin
        if (range)
            gain_d = GAIN_ONE + {3'h0, code, 2'h0};
        else
            gain_d = R0_BASE + {4'h0, code, 1'h0};
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            gain <= GAIN_ONE;
        else
            gain <= gain_d;
    end
endmodule // chfg_gain

//--- src/chfg_top.sv
// Purpose: LED channel fault handling, gain setting and status readback
// Assumes: AHB-Lite slave, single word transfers, one clock mclk
// Notes:   boost loop and serial framing are outside
// Functional notes
// - faults are judged only on active channels that have been on for at least 10 us.
// - a suspected open channel starts the regulation DAC stepping upward.
// - the suspected channel is forced on until the DAC reaches maximum or its current recovers.
// - a confirmed open with auto-disconnect set drops the channel and sets the DAC to its optimal code.
// - detection runs while the other channels keep dimming normally.
// - a six-bit gain code in config register 1 gives 64 gain steps.
// - range bit set gives 1+code*0.5/64, clear gives 0.75+code*0.25/64.
// - the gain is exactly one after reset.
// - after each brightness move in continuous mode while no queue is running, the five status words are queued out.
// - continuous readback works only in the 256-bit and 192-bit formats.
// - a confirmed open without auto-disconnect holds the DAC at maximum and pulls the fault pin low.
// - each open or shorted channel sets its own bit of the channel status register.
// - short detection is masked while the DAC is rolling up.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module chfg_top #(
    parameter int                     STEP_CYC = 4,
    parameter logic [7:0]             DAC_OPT  = 8'h80
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [15:0]          ch_pwm_on,
    input  wire logic [15:0]          ch_low_drop,
    input  wire logic [15:0]          ch_high_drop,
    output logic      [15:0]          ch_drive,
    output logic      [7:0]           dac_code,
    output logic      [10:0]          gain,
    output logic                      fault_out_n_o,
    output logic                      fault_out_n_oe_n,
    input  wire logic                 fault_out_n_i,
    input  wire logic                 bright_moved,
    output logic                      stat_valid,
    output logic      [15:0]          stat_data,
    input  wire logic                 stat_ready,
    output logic                      irq
);
    import chfg_pkg::*;
    typedef enum logic [1:0] {S_IDLE, S_RAMP, S_HOLD} chfg_state_type;
    localparam logic [DAC_W-1:0] DAC_MAX = '1;

    function automatic logic [NCH-1:0] lowest(input logic [NCH-1:0] v);
        return v & (~v + 1'b1);
    endfunction

    function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] set, input logic [15:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // ==========================================================
    // bus
    logic              wr_q, wr_d, rd_q, rd_d;
    logic [7:0]        addr_q, addr_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              acc;
    logic [15:0]       wdat;

    // ==========================================================
    // configuration and status
    logic              open_auto_disconnect_q, open_auto_disconnect_d, csr_q, csr_d, dac_overflow_flag_q, dac_overflow_flag_d;
    logic [15:0]       cfg1_q, cfg1_d, channel_select_reg_q, channel_select_reg_d, lat_q, lat_d;
    logic [15:0]       chst_q, chst_d, excl_q, excl_d;
    logic [NIRQ-1:0]   irqst_q, irqst_d, irqmsk_q, irqmsk_d;
    logic [15:0]       cfg0_w, chst_clr;
    logic [NIRQ-1:0]   ev;

    // ==========================================================
    // fault engine
    chfg_state_type    st_q, st_d;
    logic [15:0]       sus_q, sus_d;
    logic [7:0]        dac_q, dac_d;
    logic [7:0]        stp_q, stp_d;
    logic [15:0]       active, on_met, suspect, short_set, open_set;
    logic              step_done, confirm;

    // ==========================================================
    // status queue
    logic              qv_q, qv_d;
    logic [2:0]        qi_q, qi_d;
    logic [15:0]       qdat_q, qdat_d;
    logic              fmt_ok, qstart;

    assign acc       = hsel && htrans[1] && hready;
    assign wdat      = hwdata[15:0];
    assign hreadyout = !rd_q;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign cfg0_w    = {12'h000, fault_out_n_i, dac_overflow_flag_q, csr_q, open_auto_disconnect_q};
    assign chst_clr  = (wr_q && addr_q == OFS_CHANNEL_STATUS_REG) ? wdat : 16'h0000;

    always_comb begin
        wr_d    = acc && hwrite;
        rd_d    = acc && !hwrite;
        addr_d  = acc ? {haddr[7:2], 2'b00} : addr_q;
        rdata_d = rdata_q;
        if (rd_q) begin
            unique case (addr_q)
                OFS_CFG0:   rdata_d = {16'h0000, cfg0_w};
                OFS_CFG1:   rdata_d = {16'h0000, cfg1_q};
                OFS_CHANNEL_SELECT_REG:  rdata_d = {16'h0000, channel_select_reg_q};
                OFS_CHANNEL_STATUS_REG:  rdata_d = {16'h0000, chst_q};
                OFS_LAT:    rdata_d = {16'h0000, lat_q};
                OFS_IRQST:  rdata_d = {29'h0, irqst_q};
                OFS_IRQMSK: rdata_d = {29'h0, irqmsk_q};
                OFS_GAIN:   rdata_d = {21'h0, gain};
                default:    rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            addr_q  <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // registers
    always_comb begin
        open_auto_disconnect_d   = open_auto_disconnect_q;
        csr_d    = csr_q;
        cfg1_d   = cfg1_q;
        channel_select_reg_d  = channel_select_reg_q;
        lat_d    = lat_q;
        irqmsk_d = irqmsk_q;
        if (wr_q) begin
            unique case (addr_q)
                OFS_CFG0:   begin
                    open_auto_disconnect_d = wdat[B_OPEN_AUTO_DISCONNECT];
                    csr_d  = wdat[B_CSR_EN];
                end
                OFS_CFG1:   cfg1_d   = {6'h00, wdat[9:8], 1'b0, wdat[6:0]};
                OFS_CHANNEL_SELECT_REG:  channel_select_reg_d  = wdat;
                OFS_LAT:    lat_d    = wdat;
                OFS_IRQMSK: irqmsk_d = wdat[NIRQ-1:0];
                default:    ;
            endcase
        end
        chst_d = w1c(chst_q, open_set | short_set, chst_clr);
        excl_d = (excl_q & ~(chst_clr & ~(open_set | short_set)))
                 | ((confirm && open_auto_disconnect_q) ? sus_q : 16'h0000);
        dac_overflow_flag_d = confirm || (dac_overflow_flag_q && !(wr_q && addr_q == OFS_CFG0 && wdat[B_DAC_OVERFLOW_FLAG]));
        ev[IRQ_FAULT] = |(open_set | short_set);
        ev[IRQ_DAC_OVERFLOW_FLAG]  = confirm;
        ev[IRQ_QDONE] = qv_q && stat_ready && qi_q == 3'(Q_LAT);
        irqst_d = (irqst_q & ~((wr_q && addr_q == OFS_IRQST) ? wdat[NIRQ-1:0] : 3'h0)) | ev;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            open_auto_disconnect_q   <= 1'b0;
            csr_q    <= 1'b0;
            dac_overflow_flag_q   <= 1'b0;
            cfg1_q   <= RST_CFG1;
            channel_select_reg_q  <= RST_CHANNEL_SELECT_REG;
            lat_q    <= RST_LAT;
            chst_q   <= 16'h0000;
            excl_q   <= 16'h0000;
            irqst_q  <= '0;
            irqmsk_q <= '0;
        end else begin
            open_auto_disconnect_q   <= open_auto_disconnect_d;
            csr_q    <= csr_d;
            dac_overflow_flag_q   <= dac_overflow_flag_d;
            cfg1_q   <= cfg1_d;
            channel_select_reg_q  <= channel_select_reg_d;
            lat_q    <= lat_d;
            chst_q   <= chst_d;
            excl_q   <= excl_d;
            irqst_q  <= irqst_d;
            irqmsk_q <= irqmsk_d;
        end
    end

    assign irq = |(irqst_q & irqmsk_q);

    chfg_gain u_gain (
        .mclk  (mclk),
        .rst   (rst),
        .code  (cfg1_q[5:0]),
        .range (cfg1_q[B_RANGE]),
        .gain  (gain)
    );

    // ==========================================================
    // fault engine
    assign active   = channel_select_reg_q & ~excl_q;
    assign ch_drive = ((st_q == S_RAMP) ? (ch_pwm_on | sus_q) : ch_pwm_on) & active;
    assign suspect  = active & ch_drive & on_met & ch_low_drop;
    assign step_done = (stp_q == 8'(STEP_CYC - 1));
    assign confirm  = (st_q == S_RAMP) && (dac_q == DAC_MAX);
    assign open_set = confirm ? sus_q : 16'h0000;
    assign short_set = (st_q == S_RAMP) ? 16'h0000 : (active & ch_drive & on_met & ch_high_drop);
    assign dac_code = dac_q;
    assign fault_out_n_o    = 1'b0;
    assign fault_out_n_oe_n = !(|chst_q);

    chfg_ontime u_ontime (
        .mclk  (mclk),
        .rst   (rst),
        .drive (ch_drive),
        .met   (on_met)
    );

    always_comb begin
        st_d  = st_q;
        sus_d = sus_q;
        dac_d = dac_q;
        stp_d = 8'h00;
        unique case (st_q)
            S_IDLE: begin
                if (|suspect) begin
                    st_d  = S_RAMP;
                    sus_d = lowest(suspect);
                end
            end
            S_RAMP: begin
                stp_d = step_done ? 8'h00 : stp_q + 1'b1;
                if (confirm) begin
                    if (open_auto_disconnect_q) begin
                        st_d  = S_IDLE;
                        dac_d = DAC_OPT;
                    end else
                        st_d = S_HOLD;
                end else if (!(|(ch_low_drop & sus_q)))
                    st_d = S_IDLE;
                else if (step_done)
                    dac_d = dac_q + 1'b1;
            end
            S_HOLD: begin
                if (!(|(chst_q & sus_q)) || open_auto_disconnect_q) begin
                    st_d  = S_IDLE;
                    dac_d = DAC_OPT;
                end
            end
        endcase
        if (st_d == S_IDLE && st_q != S_IDLE)
            sus_d = 16'h0000;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q  <= S_IDLE;
            sus_q <= 16'h0000;
            dac_q <= DAC_OPT;
            stp_q <= 8'h00;
        end else begin
            st_q  <= st_d;
            sus_q <= sus_d;
            dac_q <= dac_d;
            stp_q <= stp_d;
        end
    end

    // ==========================================================
    // status queue
    assign fmt_ok = (cfg1_q[9:8] == FMT_256) || (cfg1_q[9:8] == FMT_192);
    assign qstart = bright_moved && csr_q && fmt_ok && !qv_q;
    assign stat_valid = qv_q;
    assign stat_data  = qdat_q;

    function automatic logic [15:0] qword(input logic [2:0] i, input logic [15:0] c0, input logic [15:0] c1,
                                          input logic [15:0] cs, input logic [15:0] st, input logic [15:0] lt);
        unique case (i)
            3'(Q_CFG0):  return c0;
            3'(Q_CFG1):  return c1;
            3'(Q_CHANNEL_SELECT_REG): return cs;
            3'(Q_CHANNEL_STATUS_REG): return st;
            default:     return lt;
        endcase
    endfunction

    always_comb begin
        qv_d   = qv_q;
        qi_d   = qi_q;
        qdat_d = qdat_q;
        if (qstart) begin
            qv_d   = 1'b1;
            qi_d   = 3'(Q_CFG0);
            qdat_d = qword(3'(Q_CFG0), cfg0_w, cfg1_q, channel_select_reg_q, chst_q, lat_q);
        end else if (qv_q && stat_ready) begin
            if (qi_q == 3'(Q_LAT))
                qv_d = 1'b0;
            else begin
                qi_d   = qi_q + 1'b1;
                qdat_d = qword(qi_q + 1'b1, cfg0_w, cfg1_q, channel_select_reg_q, chst_q, lat_q);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qv_q   <= 1'b0;
            qi_q   <= 3'h0;
            qdat_q <= 16'h0000;
        end else begin
            qv_q   <= qv_d;
            qi_q   <= qi_d;
            qdat_q <= qdat_d;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_qword(int n);
        stat_valid && qi_q == n && stat_ready;
    endsequence

    a_ontime_gate: assert property (st_q == S_IDLE && !(|(on_met & ch_low_drop & ch_drive & active))
        |=> st_q != S_RAMP) else $error("ramp started without on-time");
    a_ramp_step: assert property (st_q == S_RAMP && step_done && !confirm && (|(ch_low_drop & sus_q))
        |=> dac_q == $past(dac_q) + 8'h01) else $error("dac did not step up");
    a_force_on: assert property (st_q == S_RAMP |-> (ch_drive & sus_q) == sus_q)
        else $error("suspect channel not forced on");
    a_disconnect: assert property (confirm && open_auto_disconnect_q |=> (excl_q & $past(sus_q)) != 0
        && dac_q == DAC_OPT && (ch_drive & $past(sus_q)) == 0) else $error("open channel not dropped");
    a_other_dim: assert property (st_q == S_RAMP |->
        (ch_drive & ~sus_q) == (ch_pwm_on & active & ~sus_q)) else $error("dimming of other channels disturbed");
    a_gain_calc: assert property (##1 gain == ($past(cfg1_q[B_RANGE])
        ? 11'd512 + 11'($past(cfg1_q[5:0])) * 11'd4 : 11'd384 + 11'($past(cfg1_q[5:0])) * 11'd2))
        else $error("gain value wrong");
    a_gain_one: assert property (cfg1_q[B_RANGE] && cfg1_q[5:0] == 6'h00 |=> gain == 11'd512)
        else $error("unity gain wrong");
    a_queue_order: assert property (s_qword(0) |=> stat_valid && qi_q == 3'h1
        && stat_data == $past(cfg1_q)) else $error("queue order broken");
    a_queue_start: assert property (qstart |=> stat_valid && qi_q == 3'h0
        && stat_data == $past(cfg0_w)) else $error("status queue not started");
    a_fmt_gate: assert property (!stat_valid && cfg1_q[9:8] == FMT_16X16 |=> !stat_valid)
        else $error("readback in word format");
    a_hold_max: assert property (st_q == S_HOLD && (|(chst_q & sus_q))
        |-> dac_q == DAC_MAX && !fault_out_n_oe_n) else $error("hold without max dac or fault");
    a_status_bit: assert property (confirm |=> (chst_q & $past(sus_q)) == $past(sus_q))
        else $error("channel status bit not set");
    a_short_mask: assert property (st_q == S_RAMP |=> (chst_q & ~$past(chst_q) & ~$past(sus_q)) == 0)
        else $error("short seen during ramp");
endmodule // chfg_top

//--- verification/chfg_stat_sink.sv
// Purpose: status stream consumer standing in for the host side
// Assumes: a word is taken at an edge where valid and ready are both high
// Notes:   ready is high one cycle in three so the queue is stalled
`timescale 1ns/100ps
module chfg_stat_sink (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        stat_valid,
    input  wire logic [15:0] stat_data,
    output logic             stat_ready
);
    logic [1:0]  phase_q;
    logic [15:0] got[$];
    // ==========================================================
    // stalled acceptance of status words
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_q    <= 2'h0;
            stat_ready <= 1'b0;
        end else begin
            phase_q    <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            stat_ready <= (phase_q == 2'h1);
            if (stat_valid && stat_ready) got.push_back(stat_data);
        end
    end
endmodule // chfg_stat_sink

//--- verification/channel_fault_gain_status_tb.sv
// Purpose: self-checking bench for chfg_top
// Assumes: STEP_CYC of 1 keeps the voltage ramp short
// Notes:   fault pin has a pull-up, hready is the slave's hreadyout
`timescale 1ns/100ps
module channel_fault_gain_status_tb;
    import chfg_pkg::*;
    logic        mclk, rst, hsel, hwrite, bright_moved, hreadyout, hresp, irq;
    logic        fault_out_n_o, fault_out_n_oe_n, stat_valid, stat_ready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] ch_pwm_on, ch_low_drop, ch_high_drop, ch_drive, stat_data;
    logic [7:0]  dac_code;
    logic [10:0] gain;
    wire         fault_pin = fault_out_n_oe_n ? 1'b1 : fault_out_n_o;
    int          failures = 0;
    int          checked = 0;
    chfg_top #(.STEP_CYC(1)) dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ch_pwm_on(ch_pwm_on), .ch_low_drop(ch_low_drop),
        .ch_high_drop(ch_high_drop), .ch_drive(ch_drive), .dac_code(dac_code), .gain(gain),
        .fault_out_n_o(fault_out_n_o), .fault_out_n_oe_n(fault_out_n_oe_n), .fault_out_n_i(fault_pin),
        .bright_moved(bright_moved), .stat_valid(stat_valid), .stat_data(stat_data),
        .stat_ready(stat_ready), .irq(irq));
    chfg_stat_sink sink (.mclk(mclk), .rst(rst), .stat_valid(stat_valid), .stat_data(stat_data),
        .stat_ready(stat_ready));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic give_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk(gain, 32'h0000_0200);
        chk(dac_code, 32'h0000_0080);
        chk(hresp, 1'b0);
        ahb(1'b0, OFS_CFG1, 32'h0000_0000);
        chk(rd, 32'h0000_0040);
        ahb(1'b0, OFS_CHANNEL_SELECT_REG, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
        ahb(1'b0, 8'h20, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic t_gain;
        logic [5:0]  c;
        logic [31:0] e;
        for (int i = 0; i < 6; i++) begin
            c = (i % 3 == 0) ? 6'h00 : (i % 3 == 1) ? 6'h3F : 6'h21;
            e = i[0] ? 512 + 4 * c : 384 + 2 * c;
            ahb(1'b1, OFS_CFG1, {25'h000_0000, i[0], c});
            repeat (3) @(posedge mclk);
            chk(gain, e);
            ahb(1'b0, OFS_GAIN, 32'h0000_0000);
            chk(rd, e);
        end
        ahb(1'b1, OFS_CFG1, 32'h0000_0040);
    endtask
    task automatic t_stream;
        logic [15:0] exp_w[5];
        ahb(1'b1, OFS_LAT, 32'h0000_1234);
        ahb(1'b1, OFS_CFG0, 32'h0000_0002);
        for (int f = 0; f < 3; f++) begin
            exp_w = '{16'h000A, {6'h00, f[1:0], 8'h40}, 16'hFFFF, 16'h0000, 16'h1234};
            ahb(1'b1, OFS_CFG1, {16'h0000, exp_w[1]});
            sink.got.delete();
            bright_moved <= 1'b1;
            @(posedge mclk);
            bright_moved <= 1'b0;
            repeat (40) @(posedge mclk);
            chk(sink.got.size(), (f == 0) ? 0 : 5);
            foreach (sink.got[k]) chk(sink.got[k], exp_w[k]);
        end
        chk(irq, 1'b0);
        ahb(1'b1, OFS_IRQMSK, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        ahb(1'b1, OFS_IRQST, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
    endtask
    task automatic t_fault_open_auto_disconnect;
        ahb(1'b1, OFS_CFG0, 32'h0000_0001);
        ch_pwm_on   <= 16'h0068;
        ch_low_drop <= 16'h0008;
        repeat (2400) @(posedge mclk);
        chk(dac_code, 32'h0000_0080);
        repeat (150) @(posedge mclk);
        chk(dac_code > 8'h80, 1'b1);
        ch_pwm_on    <= 16'h0020;
        ch_high_drop <= 16'h0020;
        repeat (2) @(posedge mclk);
        chk(ch_drive, 32'h0000_0028);
        ch_high_drop <= 16'h0000;
        ch_pwm_on    <= 16'h0068;
        repeat (200) if (dac_code !== 8'hFF) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk(dac_code, 32'h0000_0080);
        chk(ch_drive[3], 1'b0);
        chk(fault_pin, 1'b0);
        ahb(1'b0, OFS_CHANNEL_STATUS_REG, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        ahb(1'b0, OFS_CFG0, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        ahb(1'b0, OFS_IRQST, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
    endtask
    task automatic t_fault_hold;
        ahb(1'b1, OFS_CFG0, 32'h0000_0004);
        ahb(1'b1, OFS_CHANNEL_STATUS_REG, 32'h0000_0008);
        repeat (3000) if (dac_code !== 8'hFF) @(posedge mclk);
        repeat (20) @(posedge mclk);
        chk(dac_code, 32'h0000_00FF);
        chk(fault_pin, 1'b0);
        ahb(1'b0, OFS_CHANNEL_STATUS_REG, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        // auto-disconnect ends the hold, the new ramp is then cut short by a recovering channel
        ahb(1'b1, OFS_CFG0, 32'h0000_0001);
        repeat (20) @(posedge mclk);
        ch_low_drop <= 16'h0000;
        repeat (20) @(posedge mclk);
        chk(dac_code > 8'h80 && dac_code < 8'hFF, 1'b1);
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (12000) @(posedge mclk);
        failures++;
        give_verdict;
    end
    initial begin
        rst = 1'b1;
        {hsel, hwrite, bright_moved, htrans, hsize} = 8'h00;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        {ch_pwm_on, ch_low_drop, ch_high_drop} = 48'h0000_0000_0000;
        hsize = 3'h2;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_gain;
        t_stream;
        t_fault_open_auto_disconnect;
        t_fault_hold;
        give_verdict;
    end
endmodule // channel_fault_gain_status_tb
